// [core/fieldbus_pkg.sv]
`default_nettype none
package fieldbus_pkg;
	typedef logic [7:0]  byte_t;
	typedef logic [15:0] word_t;

	// Function codes and the exception flag
	localparam byte_t FC_DIAG     = 8'h08;
	localparam byte_t FC_RW_MULTI = 8'h17;
	localparam byte_t EXC_FLAG    = 8'h80;

	// Exception codes
	localparam byte_t EXC_FUNC   = 8'h01;
	localparam byte_t EXC_ADDR   = 8'h02;
	localparam byte_t EXC_VALUE  = 8'h03;
	localparam byte_t EXC_DEVICE = 8'h04;
	localparam byte_t EXC_NONE   = 8'h00;

	// Diagnostics subfunctions
	localparam word_t SUB_CLEAR   = 16'h000a;
	localparam word_t SUB_BUS_MSG = 16'h000b;
	localparam word_t SUB_CRC_ERR = 16'h000c;
	localparam word_t DIAG_ZERO   = 16'h0000;

	// Register count limits of the combined request
	localparam word_t CNT_MIN = 16'h0001;
	localparam word_t CNT_MAX = 16'h0079;

	// Frame layout, byte positions and lengths
	localparam int          BUF_DEPTH   = 256;
	localparam logic [8:0]  MIN_FRAME   = 9'h004;
	localparam logic [8:0]  DIAG_LEN    = 9'h008;
	localparam logic [8:0]  RW_HDR_LEN  = 9'h00d;
	localparam logic [8:0]  EXC_LEN     = 9'h003;
	localparam logic [8:0]  DIAG_RSP    = 9'h006;
	localparam logic [7:0]  WR_DATA_POS = 8'h0b;
	localparam logic [7:0]  RD_DATA_POS = 8'h03;

	// CRC-16, reflected polynomial
	localparam word_t CRC_INIT = 16'hffff;
	localparam word_t CRC_POLY = 16'ha001;

	// Register regions open to the combined request
	localparam word_t PROC_BASE = 16'h1000;
	localparam word_t PROC_LAST = 16'h1fff;
	localparam word_t APP_BASE = 16'h2000;
	localparam word_t APP_LAST = 16'h2fff;

	typedef enum logic [4:0] {
		ST_IDLE   = 5'h01,
		ST_DECODE = 5'h02,
		ST_WRITE  = 5'h04,
		ST_READ   = 5'h08,
		ST_SEND   = 5'h10
	} state_t;

	function automatic logic count_ok(input word_t n);
		count_ok = (n >= CNT_MIN) && (n <= CNT_MAX);
	endfunction : count_ok

	// Whole span must sit inside one region
	function automatic logic in_region(input word_t addr, input logic [6:0] n);
		logic [16:0] last;
		last = {1'b0, addr} + {10'h000, n} - 17'h00001;
		in_region = (addr >= PROC_BASE && last <= {1'b0, PROC_LAST}) ||
			(addr >= APP_BASE && last <= {1'b0, APP_LAST});
	endfunction : in_region
endpackage : fieldbus_pkg
`default_nettype wire

// [core/crc16_unit.sv]
`timescale 1ns/1ns
`default_nettype none
module crc16_unit (
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                arst_n,
	// Byte feed
	input  wire logic                init,
	input  wire logic                en,
	input  wire fieldbus_pkg::byte_t data,
	// Checksum
	output fieldbus_pkg::word_t      crc,
	output fieldbus_pkg::word_t      next_crc
);
	import fieldbus_pkg::*;

	always_comb begin
		word_t c;
		c = crc ^ {8'h00, data};
		for (int i = 0; i < 8; i++) begin
			c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		end
		next_crc = c;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			crc <= CRC_INIT;
		end else if (init) begin
			crc <= CRC_INIT;
		end else if (en) begin
			crc <= next_crc;
		end
	end
endmodule : crc16_unit
`default_nettype wire

// [core/fieldbus_rw_diag_handler.sv]
`timescale 1ns/1ns
`default_nettype none
module fieldbus_rw_diag_handler (
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                arst_n,
	// Configuration
	input  wire fieldbus_pkg::byte_t node_addr,
	input  wire logic                restart,
	// Received bytes
	input  wire logic                rx_valid,
	input  wire fieldbus_pkg::byte_t rx_data,
	input  wire logic                rx_frame_end,
	// Transmitted bytes
	output logic                     tx_valid,
	input  wire logic                tx_ready,
	output fieldbus_pkg::byte_t      tx_data,
	output logic                     tx_last,
	// Register access
	output logic                     reg_req,
	output logic                     reg_we,
	output fieldbus_pkg::word_t      reg_addr,
	output fieldbus_pkg::word_t      reg_wdata,
	input  wire logic                reg_ack,
	input  wire logic                reg_fault,
	input  wire fieldbus_pkg::word_t reg_rdata,
	// Diagnostic counters
	output fieldbus_pkg::word_t      bus_msg_count,
	output fieldbus_pkg::word_t      crc_err_count
);
	import fieldbus_pkg::*;

	state_t     state, next_state;
	byte_t      rx_buf [BUF_DEPTH];
	byte_t      tx_buf [BUF_DEPTH];
	byte_t      fc, bcnt, dec_exc;
	logic [8:0] rx_len, frame_len, tx_idx, tx_nidx, tx_len;
	logic [7:0] wr_ptr;
	logic [6:0] idx, wr_cnt, rd_cnt;
	word_t      rx_crc, tx_crc, tx_crc_nxt, rd_base, sub, ddata, diag_word;
	word_t      rd_addr, rd_n, wr_addr, wr_n;
	logic       rx_ovf, rx_en, frame_ok, crc_bad, go, clear_req, enter_send;
	logic       acc_done, acc_fault, wr_last, rd_last, tx_fire;

	// Bytes are only taken while idle; later ones are dropped
	assign rx_en = rx_valid && state == ST_IDLE && !rx_ovf;

	always_ff @(posedge clk) begin
		if (rx_en && rx_len != 9'(BUF_DEPTH)) begin
			rx_buf[rx_len[7:0]] <= rx_data;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_len    <= 9'h000;
			rx_ovf    <= 1'b0;
			frame_len <= 9'h000;
		end else if (rx_frame_end) begin
			rx_len    <= 9'h000;
			rx_ovf    <= 1'b0;
			frame_len <= rx_len;
		end else if (rx_en) begin
			if (rx_len == 9'(BUF_DEPTH)) begin
				rx_ovf <= 1'b1;
			end else begin
				rx_len <= rx_len + 9'h001;
			end
		end
	end

	crc16_unit rx_crc_unit (
		.clk      (clk),
		.arst_n   (arst_n),
		.init     (rx_frame_end),
		.en       (rx_en && rx_len != 9'(BUF_DEPTH)),
		.data     (rx_data),
		.crc      (rx_crc),
		.next_crc ()
	);

	assign frame_ok = rx_frame_end && state == ST_IDLE && rx_len >= MIN_FRAME &&
		!rx_ovf && rx_crc == 16'h0000;
	assign crc_bad = rx_frame_end && state == ST_IDLE && rx_len != 9'h000 && !frame_ok;
	assign go = frame_ok && rx_buf[0] == node_addr;

	assign fc      = rx_buf[1];
	assign sub     = {rx_buf[2], rx_buf[3]};
	assign ddata   = {rx_buf[4], rx_buf[5]};
	assign rd_addr = {rx_buf[2], rx_buf[3]};
	assign rd_n    = {rx_buf[4], rx_buf[5]};
	assign wr_addr = {rx_buf[6], rx_buf[7]};
	assign wr_n    = {rx_buf[8], rx_buf[9]};
	assign bcnt    = rx_buf[10];

	always_comb begin
		dec_exc = EXC_NONE;
		if (fc == FC_DIAG) begin
			if (sub != SUB_CLEAR && sub != SUB_BUS_MSG && sub != SUB_CRC_ERR) begin
				dec_exc = EXC_FUNC;
			end else if (frame_len != DIAG_LEN || ddata != DIAG_ZERO) begin
				dec_exc = EXC_VALUE;
			end
		end else if (fc == FC_RW_MULTI) begin
			if (!count_ok(rd_n) || !count_ok(wr_n) || bcnt != {wr_n[6:0], 1'b0} ||
				frame_len != RW_HDR_LEN + {1'b0, bcnt}) begin
				dec_exc = EXC_VALUE;
			end else if (!in_region(rd_addr, rd_n[6:0]) || !in_region(wr_addr, wr_n[6:0])) begin
				dec_exc = EXC_ADDR;
			end
		end else begin
			dec_exc = EXC_FUNC;
		end
	end

	always_comb begin
		unique case (sub)
			SUB_BUS_MSG: diag_word = bus_msg_count;
			SUB_CRC_ERR: diag_word = crc_err_count;
			default:     diag_word = ddata;
		endcase
	end

	assign acc_done  = reg_ack && !reg_fault;
	assign acc_fault = reg_ack && reg_fault;
	assign wr_last   = idx == wr_cnt - 7'h01;
	assign rd_last   = idx == rd_cnt - 7'h01;
	assign tx_fire   = tx_valid && tx_ready;
	assign tx_nidx   = tx_idx + 9'h001;

	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE:   if (go) next_state = ST_DECODE;
			ST_DECODE: begin
				if (dec_exc == EXC_NONE && fc == FC_RW_MULTI) begin
					next_state = ST_WRITE;
				end else begin
					next_state = ST_SEND;
				end
			end
			// write phase hands over to read phase
			ST_WRITE: begin
				if (acc_fault) begin
					next_state = ST_SEND;
				end else if (acc_done && wr_last) begin
					next_state = ST_READ;
				end
			end
			ST_READ:   if (acc_fault || (acc_done && rd_last)) next_state = ST_SEND;
			ST_SEND:   if (tx_fire && tx_idx == tx_len + 9'h001) next_state = ST_IDLE;
			default:   next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	assign enter_send = next_state == ST_SEND && state != ST_SEND;
	assign reg_req    = state == ST_WRITE || state == ST_READ;
	assign reg_we     = state == ST_WRITE;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			idx       <= 7'h00;
			wr_cnt    <= 7'h00;
			rd_cnt    <= 7'h00;
			rd_base   <= 16'h0000;
			reg_addr  <= 16'h0000;
			reg_wdata <= 16'h0000;
			wr_ptr    <= 8'h00;
		end else if (state == ST_DECODE) begin
			idx       <= 7'h00;
			wr_cnt    <= wr_n[6:0];
			rd_cnt    <= rd_n[6:0];
			rd_base   <= rd_addr;
			reg_addr  <= wr_addr;
			wr_ptr    <= WR_DATA_POS;
			reg_wdata <= {rx_buf[WR_DATA_POS], rx_buf[WR_DATA_POS + 8'h01]};
		end else if (state == ST_WRITE && acc_done) begin
			// after the last write, reads start at their own base
			idx       <= wr_last ? 7'h00 : idx + 7'h01;
			reg_addr  <= wr_last ? rd_base : reg_addr + 16'h0001;
			wr_ptr    <= wr_ptr + 8'h02;
			reg_wdata <= {rx_buf[wr_ptr + 8'h02], rx_buf[wr_ptr + 8'h03]};
		end else if (state == ST_READ && acc_done) begin
			idx      <= idx + 7'h01;
			reg_addr <= reg_addr + 16'h0001;
		end
	end

	// Response image; no reset needed, always built before use
	always_ff @(posedge clk) begin
		if (state == ST_DECODE) begin
			tx_buf[0] <= node_addr;
			if (dec_exc != EXC_NONE) begin
				tx_buf[1] <= fc | EXC_FLAG;
				tx_buf[2] <= dec_exc;
			end else if (fc == FC_DIAG) begin
				tx_buf[1] <= fc;
				tx_buf[2] <= rx_buf[2];
				tx_buf[3] <= rx_buf[3];
				tx_buf[4] <= diag_word[15:8];
				tx_buf[5] <= diag_word[7:0];
			end else begin
				tx_buf[1] <= fc;
				tx_buf[2] <= {rd_n[6:0], 1'b0};
			end
		end else if (reg_req && acc_fault) begin
			tx_buf[1] <= FC_RW_MULTI | EXC_FLAG;
			tx_buf[2] <= EXC_DEVICE;
		end else if (state == ST_READ && acc_done) begin
			tx_buf[RD_DATA_POS + {idx, 1'b0}]         <= reg_rdata[15:8];
			tx_buf[RD_DATA_POS + {idx, 1'b0} + 8'h01] <= reg_rdata[7:0];
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_len <= EXC_LEN;
		end else if (state == ST_DECODE) begin
			if (dec_exc != EXC_NONE) begin
				tx_len <= EXC_LEN;
			end else if (fc == FC_DIAG) begin
				tx_len <= DIAG_RSP;
			end else begin
				tx_len <= EXC_LEN + {1'b0, rd_n[6:0], 1'b0};
			end
		end else if (reg_req && acc_fault) begin
			tx_len <= EXC_LEN;
		end
	end

	crc16_unit tx_crc_unit (
		.clk      (clk),
		.arst_n   (arst_n),
		.init     (enter_send),
		.en       (tx_fire && tx_idx < tx_len),
		.data     (tx_data),
		.crc      (tx_crc),
		.next_crc (tx_crc_nxt)
	);

	assign tx_valid = state == ST_SEND;
	assign tx_last  = tx_valid && tx_idx == tx_len + 9'h001;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_idx  <= 9'h000;
			tx_data <= 8'h00;
		end else if (enter_send) begin
			tx_idx  <= 9'h000;
			tx_data <= node_addr;
		end else if (tx_fire) begin
			tx_idx <= tx_nidx;
			if (tx_nidx < tx_len) begin
				tx_data <= tx_buf[tx_nidx[7:0]];
			end else if (tx_nidx == tx_len) begin
				tx_data <= tx_crc_nxt[7:0];
			end else begin
				tx_data <= tx_crc[15:8];
			end
		end
	end

	assign clear_req = restart ||
		(state == ST_DECODE && dec_exc == EXC_NONE && fc == FC_DIAG && sub == SUB_CLEAR);

	// wrap at 16 bits; a count in the clear cycle survives
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bus_msg_count <= 16'h0000;
			crc_err_count <= 16'h0000;
		end else if (clear_req) begin
			bus_msg_count <= {15'h0000, rx_frame_end};
			crc_err_count <= {15'h0000, crc_bad};
		end else begin
			bus_msg_count <= bus_msg_count + {15'h0000, rx_frame_end};
			crc_err_count <= crc_err_count + {15'h0000, crc_bad};
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	sequence last_write;
		state == ST_WRITE && acc_done && wr_last;
	endsequence

	rw_order_a: assert property (last_write |=> state == ST_READ && reg_addr == rd_base)
		else $error("read phase did not follow last write");
	region_gate_a: assert property (reg_req |-> in_region(reg_addr, 7'h01))
		else $error("register access outside allowed regions");
	rd_range_a: assert property (state == ST_READ |-> rd_cnt != 7'h00 && rd_cnt <= CNT_MAX[6:0])
		else $error("read count out of range");
	wr_range_a: assert property (state == ST_WRITE |-> wr_cnt != 7'h00 && wr_cnt <= CNT_MAX[6:0])
		else $error("write count out of range");
	bytecount_a: assert property (state == ST_DECODE && fc == FC_RW_MULTI && dec_exc == EXC_NONE
		|-> bcnt == {wr_n[6:0], 1'b0})
		else $error("byte count mismatch accepted");
	resp_len_a: assert property (state == ST_DECODE && fc == FC_RW_MULTI && dec_exc == EXC_NONE
		|=> tx_len == EXC_LEN + {1'b0, rd_cnt, 1'b0} && tx_buf[2] == {rd_cnt, 1'b0})
		else $error("normal reply length wrong");
	exc_reply_a: assert property (tx_valid && tx_buf[1][7] |-> tx_len == EXC_LEN &&
		tx_buf[2] >= EXC_FUNC && tx_buf[2] <= EXC_DEVICE)
		else $error("exception reply malformed");
	diag_echo_a: assert property (tx_valid && tx_buf[1] == FC_DIAG |-> tx_len == DIAG_RSP)
		else $error("diagnostics reply length wrong");
	clear_cnt_a: assert property (clear_req && !rx_frame_end
		|=> bus_msg_count == 16'h0000 && crc_err_count == 16'h0000)
		else $error("counters not cleared");
	msg_count_a: assert property (rx_frame_end && !clear_req
		|=> bus_msg_count == $past(bus_msg_count) + 16'h0001)
		else $error("bus message count not advanced");
	crc_err_a: assert property (crc_bad && !clear_req
		|=> crc_err_count == $past(crc_err_count) + 16'h0001 && state == ST_IDLE)
		else $error("bad frame not counted or not discarded");
	tx_end_a: assert property (tx_last && tx_ready |=> state == ST_IDLE ##1 !tx_valid)
		else $error("reply did not end after checksum");
endmodule : fieldbus_rw_diag_handler
`default_nettype wire

// [testbench/modbus_client_model.sv]
`timescale 1ns/1ns
`default_nettype none
module modbus_client_model (
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                arst_n,
	// Request bytes
	output logic                     rx_valid,
	output fieldbus_pkg::byte_t      rx_data,
	output logic                     rx_frame_end,
	// Reply bytes
	input  wire logic                tx_valid,
	input  wire fieldbus_pkg::byte_t tx_data,
	input  wire logic                tx_last,
	output logic                     tx_ready
);
	import fieldbus_pkg::*;
	logic slow = 1'b0;
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_frame_end = 1'b0;
		tx_ready = 1'b0;
	end

	function automatic word_t crc_of(input byte_t q[$]);
		word_t c;
		c = 16'hffff;
		foreach (q[i]) begin
			c = c ^ {8'h00, q[i]};
			for (int b = 0; b < 8; b++) begin
				c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
			end
		end
		return c;
	endfunction : crc_of

	// whole frame, CRC low byte first
	task automatic send(input byte_t q[$], input logic bad);
		word_t c;
		c = crc_of(q) ^ {15'h0000, bad};
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
		foreach (q[i]) begin
			rx_valid <= 1'b1;
			rx_data <= q[i];
			@(posedge clk);
			#1;
		end
		// Idle line shows no stale byte
		rx_valid <= 1'b0;
		rx_data <= ~q[q.size() - 1];
		rx_frame_end <= 1'b1;
		@(posedge clk);
		#1;
		rx_frame_end <= 1'b0;
	endtask : send

	// Slow mode accepts only every other cycle
	task automatic recv(output byte_t r[$], output logic ok);
		int n;
		r = {};
		ok = 1'b0;
		n = 0;
		while (n < 600 && !ok) begin
			tx_ready <= !slow || n[0];
			@(posedge clk);
			if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
				r.push_back(tx_data);
				ok = (tx_last === 1'b1);
			end
			#1;
			n++;
		end
		tx_ready <= 1'b0;
		@(posedge clk);
		#1;
	endtask : recv
endmodule : modbus_client_model
`default_nettype wire

// [testbench/fieldbus_rw_diag_handler_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module fieldbus_rw_diag_handler_tb;
	import fieldbus_pkg::*;
	typedef byte_t bq_t[$];
	localparam byte_t NODE = 8'h05;
	logic  clk, arst_n, restart, rx_valid, rx_frame_end, tx_valid, tx_ready, tx_last;
	logic  reg_req, reg_we, reg_ack = 1'b0, reg_fault = 1'b0;
	byte_t node_addr, rx_data, tx_data;
	word_t reg_addr, reg_wdata, reg_rdata = 16'h0000, bus_msg_count, crc_err_count;
	word_t fault_addr = 16'hffff;
	word_t mem [0:255];
	int    miscompares = 0, check_count = 0;

	fieldbus_rw_diag_handler dut_u (.clk(clk), .arst_n(arst_n), .node_addr(node_addr),
		.restart(restart), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_frame_end(rx_frame_end), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.tx_data(tx_data), .tx_last(tx_last), .reg_req(reg_req), .reg_we(reg_we),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_ack(reg_ack),
		.reg_fault(reg_fault), .reg_rdata(reg_rdata), .bus_msg_count(bus_msg_count),
		.crc_err_count(crc_err_count));
	modbus_client_model client_u (.clk(clk), .arst_n(arst_n), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_frame_end(rx_frame_end), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Register side acks every other cycle while requested, the first one at once
	always @(posedge clk) begin
		if (reg_ack === 1'b1 && reg_we === 1'b1) mem[reg_addr[7:0]] = reg_wdata;
		#1;
		reg_ack = !reg_ack && reg_req === 1'b1;
		reg_fault = reg_ack && reg_addr === fault_addr;
		reg_rdata = reg_ack ? mem[reg_addr[7:0]] : ~reg_rdata;
	end

	task automatic check(input word_t seen, input word_t exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %0t got %h want %h", $time, seen, exp);
		end
	endtask : check

	task automatic tally_and_finish();
		if (miscompares == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : tally_and_finish

	function automatic bq_t dq(input word_t s, input word_t d);
		return '{NODE, FC_DIAG, s[15:8], s[7:0], d[15:8], d[7:0]};
	endfunction : dq

	function automatic bq_t rwq(input word_t ra, input word_t rc, input word_t wa,
		input word_t wc);
		bq_t q;
		q = '{NODE, FC_RW_MULTI, ra[15:8], ra[7:0], rc[15:8], rc[7:0], wa[15:8], wa[7:0],
			wc[15:8], wc[7:0], byte_t'(2 * wc)};
		for (int i = 0; i < 2 * wc; i++) q.push_back(byte_t'(i + 1));
		return q;
	endfunction : rwq

	task automatic xact(input bq_t q, input bq_t e);
		bq_t   r;
		logic  ok;
		word_t c;
		c = client_u.crc_of(e);
		e.push_back(c[7:0]);
		e.push_back(c[15:8]);
		client_u.send(q, 1'b0);
		client_u.recv(r, ok);
		if (!ok) begin
			miscompares++;
			$display("CHECK FAILED %0t reply timed out", $time);
			tally_and_finish();
		end
		check(word_t'(r.size()), word_t'(e.size()));
		foreach (e[i]) check({8'h00, r[i]}, {8'h00, e[i]});
	endtask : xact

	task automatic silent();
		for (int n = 0; n < 30; n++) begin
			@(posedge clk);
			check({15'h0000, tx_valid}, 16'h0000);
		end
		#1;
	endtask : silent

	task automatic t_counts();
		check(bus_msg_count, 16'h0000);
		client_u.send(dq(SUB_BUS_MSG, 16'h0000), 1'b1);
		silent();
		client_u.send('{8'h06, FC_DIAG, 8'h00, 8'h0b, 8'h00, 8'h00}, 1'b0);
		silent();
		xact(dq(SUB_BUS_MSG, 16'h0000), dq(SUB_BUS_MSG, 16'h0003));
		xact(dq(SUB_CRC_ERR, 16'h0000), dq(SUB_CRC_ERR, 16'h0001));
		xact(dq(SUB_CLEAR, 16'h0000), dq(SUB_CLEAR, 16'h0000));
		check(bus_msg_count, 16'h0000);
		check(crc_err_count, 16'h0000);
		client_u.send(dq(SUB_BUS_MSG, 16'h0000), 1'b1);
		silent();
		restart <= 1'b1;
		@(posedge clk);
		#1;
		restart <= 1'b0;
		@(posedge clk);
		#1;
		check(crc_err_count, 16'h0000);
		check(bus_msg_count, 16'h0000);
		// Mid-run power-on reset must clear counts too
		client_u.send(dq(SUB_BUS_MSG, 16'h0000), 1'b1);
		silent();
		arst_n = 1'b0;
		@(posedge clk);
		#1;
		check(bus_msg_count, 16'h0000);
		check(crc_err_count, 16'h0000);
		arst_n = 1'b1;
		@(posedge clk);
		#1;
	endtask : t_counts

	task automatic t_rw();
		client_u.slow = 1'b1;
		xact(rwq(16'h1000, 16'h0002, 16'h1000, 16'h0002),
			'{NODE, FC_RW_MULTI, 8'h04, 8'h01, 8'h02, 8'h03, 8'h04});
		client_u.slow = 1'b0;
		check(mem[0], 16'h0102);
		check(mem[1], 16'h0304);
		mem[0] = 16'h0000;
		xact(rwq(16'h1ffe, 16'h0002, 16'h2000, 16'h0001),
			'{NODE, FC_RW_MULTI, 8'h04, 8'ha5, 8'hfe, 8'ha5, 8'hff});
		check(mem[0], 16'h0102);
	endtask : t_rw

	task automatic t_errors();
		bq_t q;
		xact('{NODE, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, '{NODE, 8'h83, 8'h01});
		xact(dq(16'h000d, 16'h0000), '{NODE, 8'h88, 8'h01});
		xact(dq(SUB_BUS_MSG, 16'h0001), '{NODE, 8'h88, 8'h03});
		xact(rwq(16'h1000, 16'h0000, 16'h1000, 16'h0001), '{NODE, 8'h97, 8'h03});
		xact(rwq(16'h1000, 16'h007a, 16'h1000, 16'h0001), '{NODE, 8'h97, 8'h03});
		xact(rwq(16'h1000, 16'h0001, 16'h1000, 16'h0000), '{NODE, 8'h97, 8'h03});
		xact(rwq(16'h1fff, 16'h0002, 16'h1000, 16'h0001), '{NODE, 8'h97, 8'h02});
		xact(rwq(16'h1000, 16'h0001, 16'h0fff, 16'h0001), '{NODE, 8'h97, 8'h02});
		// Byte count twice too big, frame length still consistent
		q = rwq(16'h1000, 16'h0001, 16'h1000, 16'h0001);
		q[10] = 8'h04;
		q.push_back(8'h00);
		q.push_back(8'h00);
		xact(q, '{NODE, 8'h97, 8'h03});
		fault_addr = 16'h1005;
		xact(rwq(16'h1000, 16'h0001, 16'h1005, 16'h0001), '{NODE, 8'h97, 8'h04});
	endtask : t_errors

	initial begin
		foreach (mem[i]) mem[i] = word_t'(i) ^ 16'ha500;
		arst_n = 1'b0;
		restart = 1'b0;
		node_addr = NODE;
		repeat (12) @(posedge clk);
		#1;
		arst_n = 1'b1;
		@(posedge clk);
		#1;
		t_counts();
		t_rw();
		t_errors();
		tally_and_finish();
	end
endmodule : fieldbus_rw_diag_handler_tb
`default_nettype wire
